/* core/csf_pkg.sv */
package csf_pkg;
	// Register indices; the bus byte address is four times the index
	localparam logic [7:0] IDX_PHASE_OFFSET_VALUE_HI   = 8'h4B;
	localparam logic [7:0] IDX_PHASE_OFFSET_VALUE_LO   = 8'h4C;
	localparam logic [7:0] IDX_PHADJ     = 8'h4D;
	localparam logic [7:0] IDX_OUT1      = 8'h53;
	localparam logic [7:0] IDX_OUT2      = 8'h54;
	localparam logic [7:0] IDX_OUT3      = 8'h55;
	localparam logic [7:0] IDX_GLOB_SUM  = 8'h43;
	localparam logic [7:0] IDX_OUT_SUM   = 8'h45;
	localparam logic [7:0] IDX_SLOW_CTRL = 8'h60;
	localparam int         NUM_OUT       = 3;
	// Measurement high register fields
	localparam int MH_OVF   = 6;
	localparam int MH_MEASURE_READY_IRQ_EN = 5;
	localparam int MH_RDY   = 4;
	localparam int MH_BUSY  = 3;
	// Phase adjust fields
	localparam int PA_IE    = 3;
	localparam int PA_DONE  = 2;
	localparam int PA_BUSY  = 1;
	localparam int PA_ARMED = 0;
	// Output clock status fields
	localparam int OC_SLIE  = 7;
	localparam int OC_SLL   = 6;
	localparam int OC_SLV   = 5;
	localparam int OC_RSIE  = 4;
	localparam int OC_RSL   = 3;
	localparam int OC_HLIE  = 2;
	localparam int OC_HLL   = 1;
	localparam int OC_HLV   = 0;
	// Summary bit positions
	localparam int GS_PA  = 1;
	localparam int GS_PHASE_OFFSET_VALUE = 0;
	// Reset value and AHB bus encodings
	localparam logic [7:0] PHADJ_RST = 8'h84;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : csf_pkg

/* core/csf_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Overflow flag set when measurement overflowed
// - Ready enable gates ready flag request
// - Ready flag latched on new result
// - Measurement busy reads live
// - Eleven-bit offset split across two registers
// - Offset spans plus 1023 to minus 1024
// - Adjust enable gates done flag request
// - Done flag latched, write one clears
// - Adjust busy reads live
// - Armed reads live, cleared by trigger
// - Three identical output status registers
// - Slow edge enable gates edge flag request
// - Slow rising edge latched, write clears
// - Slow level reported inverted when enabled
// - Resume enable gates resume flag request
// - Resume latched after stop, write clears
// - Halt enable gates halt flag request
// - Halt latched on stop, write clears
// - Halt level reads live
// - Clock-path flags held at zero until path ready
// - Phase adjust summary bit
// - Measurement summary bit
// - Per-output summary bits
module csf_top #(
	parameter int NOUT = csf_pkg::NUM_OUT
) (
	input  wire logic             CORE_CLK,     // 200 MHz clock
	input  wire logic             RST,          // Async reset, high
	input  wire logic             HSEL,         // AHB select
	input  wire logic [31:0]      HADDR,        // AHB address
	input  wire logic [1:0]       HTRANS,       // AHB transfer type
	input  wire logic             HWRITE,       // AHB write
	input  wire logic [2:0]       HSIZE,        // AHB size
	input  wire logic [31:0]      HWDATA,       // AHB write data
	input  wire logic             HREADY,       // AHB bus ready
	output logic      [31:0]      HRDATA,       // AHB read data
	output logic                  HREADYOUT,    // AHB slave ready
	output logic                  HRESP,        // AHB response
	input  wire logic             PHASE_OFFSET_VALUE_DONE,    // Measurement finished pulse
	input  wire logic             PHASE_OFFSET_VALUE_OVF,     // Overflow with PHASE_OFFSET_VALUE_DONE
	input  wire logic [10:0]      PHASE_OFFSET_VALUE_VALUE,   // Signed result
	input  wire logic             PHASE_OFFSET_VALUE_BUSY,    // Measurement running
	input  wire logic             ADJ_DONE,     // Adjust complete pulse
	input  wire logic             ADJ_BUSY,     // Adjust running
	input  wire logic             ADJ_ARMED,    // Adjust armed
	input  wire logic [NOUT-1:0]  SLOW_CLK,     // Slow divider levels
	input  wire logic [NOUT-1:0]  CLK_STOPPED,  // Output stopped levels
	input  wire logic [NOUT-1:0]  PATH_READY,   // Output path clocked
	output logic                  PA_IRQ,       // Phase adjust summary
	output logic                  PHASE_OFFSET_VALUE_IRQ,     // Measurement summary
	output logic      [NOUT-1:0]  OUT_IRQ       // Per-output summary
);
	logic        ap_write_ff;
	logic        ap_read_ff;
	logic [7:0]  ap_addr_ff;
	logic        phase_offset_value_ovf_ff;
	logic        phase_offset_value_rdy_ff;
	logic        phase_offset_value_ie_ff;
	logic [10:0] phase_offset_value_val_ff;
	logic        phase_offset_value_busy_ff;
	logic        adj_done_ff;
	logic        adj_ie_ff;
	logic        adj_busy_ff;
	logic        adj_armed_ff;
	logic [NOUT-1:0] slow_prev_ff;
	logic [NOUT-1:0] stop_prev_ff;
	logic [NOUT-1:0] slow_rep_en_ff;
	logic [7:0]  oc_ff [NOUT];
	logic [7:0]  wbyte;
	logic        wr_hit;
	logic [7:0]  rd_mux;
	logic        edge_arm_ff;

	function automatic logic wr_one(input logic [7:0] a, input int b);
		wr_one = ap_write_ff && (ap_addr_ff == a) && wbyte[b];
	endfunction : wr_one

	assign wbyte  = HWDATA[7:0];
	assign wr_hit = ap_write_ff;

	// Address phase capture; writes take zero wait states
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ap_write_ff <= 1'b0;
			ap_read_ff  <= 1'b0;
			ap_addr_ff  <= 8'h00;
		end else begin
			ap_write_ff <= HSEL && HREADY && HTRANS[1] && HWRITE;
			ap_read_ff  <= HSEL && HREADY && HTRANS[1] && !HWRITE;
			ap_addr_ff  <= HADDR[9:2];
		end
	end

	// Edge detectors have no history on the first cycle out of reset;
	// skip it so a pin already high is not taken for an edge
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			edge_arm_ff <= 1'b0;
		else
			edge_arm_ff <= 1'b1;
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			phase_offset_value_ovf_ff <= 1'b0;
			phase_offset_value_rdy_ff <= 1'b0;
			phase_offset_value_ie_ff  <= 1'b0;
			phase_offset_value_val_ff <= 11'h000;
			phase_offset_value_busy_ff <= 1'b0;
		end else begin
			if (PHASE_OFFSET_VALUE_DONE)
				phase_offset_value_ovf_ff <= PHASE_OFFSET_VALUE_OVF;
			else if (wr_one(csf_pkg::IDX_PHASE_OFFSET_VALUE_HI, csf_pkg::MH_OVF))
				phase_offset_value_ovf_ff <= 1'b0;
			if (PHASE_OFFSET_VALUE_DONE)
				phase_offset_value_rdy_ff <= 1'b1;
			else if (wr_one(csf_pkg::IDX_PHASE_OFFSET_VALUE_HI, csf_pkg::MH_RDY))
				phase_offset_value_rdy_ff <= 1'b0;
			if (wr_hit && ap_addr_ff == csf_pkg::IDX_PHASE_OFFSET_VALUE_HI)
				phase_offset_value_ie_ff <= wbyte[csf_pkg::MH_MEASURE_READY_IRQ_EN];
			if (PHASE_OFFSET_VALUE_DONE)
				phase_offset_value_val_ff <= PHASE_OFFSET_VALUE_VALUE;
			phase_offset_value_busy_ff <= PHASE_OFFSET_VALUE_BUSY;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			adj_done_ff  <= csf_pkg::PHADJ_RST[csf_pkg::PA_DONE];
			adj_ie_ff    <= csf_pkg::PHADJ_RST[csf_pkg::PA_IE];
			adj_busy_ff  <= csf_pkg::PHADJ_RST[csf_pkg::PA_BUSY];
			adj_armed_ff <= csf_pkg::PHADJ_RST[csf_pkg::PA_ARMED];
		end else begin
			if (ADJ_DONE)
				adj_done_ff <= 1'b1;
			else if (wr_one(csf_pkg::IDX_PHADJ, csf_pkg::PA_DONE))
				adj_done_ff <= 1'b0;
			if (wr_hit && ap_addr_ff == csf_pkg::IDX_PHADJ)
				adj_ie_ff <= wbyte[csf_pkg::PA_IE];
			adj_busy_ff  <= ADJ_BUSY;
			adj_armed_ff <= ADJ_ARMED;
		end
	end

	// Slow level report enables
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			slow_rep_en_ff <= '0;
		else if (wr_hit && ap_addr_ff == csf_pkg::IDX_SLOW_CTRL)
			slow_rep_en_ff <= wbyte[NOUT-1:0];
	end

	for (genvar i = 0; i < NOUT; i++) begin : g_out
		logic [7:0] my_addr;
		logic       wr_me;
		assign my_addr = csf_pkg::IDX_OUT1 + 8'(i);
		assign wr_me   = wr_hit && ap_addr_ff == my_addr;
		always_ff @(posedge CORE_CLK or posedge RST) begin
			if (RST) begin
				oc_ff[i]        <= 8'h00;
				slow_prev_ff[i] <= 1'b0;
				stop_prev_ff[i] <= 1'b0;
			end else begin
				slow_prev_ff[i] <= SLOW_CLK[i];
				stop_prev_ff[i] <= CLK_STOPPED[i];
				if (wr_me) begin
					oc_ff[i][csf_pkg::OC_SLIE] <= wbyte[csf_pkg::OC_SLIE];
					oc_ff[i][csf_pkg::OC_RSIE] <= wbyte[csf_pkg::OC_RSIE];
					oc_ff[i][csf_pkg::OC_HLIE] <= wbyte[csf_pkg::OC_HLIE];
				end
				if (edge_arm_ff && SLOW_CLK[i] && !slow_prev_ff[i])
					oc_ff[i][csf_pkg::OC_SLL] <= 1'b1;
				else if (wr_me && wbyte[csf_pkg::OC_SLL])
					oc_ff[i][csf_pkg::OC_SLL] <= 1'b0;
				oc_ff[i][csf_pkg::OC_SLV] <= slow_rep_en_ff[i] && !SLOW_CLK[i];
				// held at zero until path ready
				if (!PATH_READY[i]) begin
					oc_ff[i][csf_pkg::OC_RSL] <= 1'b0;
					oc_ff[i][csf_pkg::OC_HLL] <= 1'b0;
					oc_ff[i][csf_pkg::OC_HLV] <= 1'b0;
				end else begin
					if (edge_arm_ff && !CLK_STOPPED[i]
						&& stop_prev_ff[i])
						oc_ff[i][csf_pkg::OC_RSL] <= 1'b1;
					else if (wr_me && wbyte[csf_pkg::OC_RSL])
						oc_ff[i][csf_pkg::OC_RSL] <= 1'b0;
					if (edge_arm_ff && CLK_STOPPED[i]
						&& !stop_prev_ff[i])
						oc_ff[i][csf_pkg::OC_HLL] <= 1'b1;
					else if (wr_me && wbyte[csf_pkg::OC_HLL])
						oc_ff[i][csf_pkg::OC_HLL] <= 1'b0;
					oc_ff[i][csf_pkg::OC_HLV] <= CLK_STOPPED[i];
				end
			end
		end
		always_ff @(posedge CORE_CLK or posedge RST) begin
			if (RST)
				OUT_IRQ[i] <= 1'b0;
			else
				OUT_IRQ[i] <= (oc_ff[i][csf_pkg::OC_SLIE] && oc_ff[i][csf_pkg::OC_SLL])
					|| (oc_ff[i][csf_pkg::OC_RSIE] && oc_ff[i][csf_pkg::OC_RSL])
					|| (oc_ff[i][csf_pkg::OC_HLIE] && oc_ff[i][csf_pkg::OC_HLL]);
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			PA_IRQ   <= 1'b0;
			PHASE_OFFSET_VALUE_IRQ <= 1'b0;
		end else begin
			PA_IRQ   <= adj_ie_ff && adj_done_ff;
			PHASE_OFFSET_VALUE_IRQ <= phase_offset_value_ie_ff && phase_offset_value_rdy_ff;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (ap_addr_ff)
			csf_pkg::IDX_PHASE_OFFSET_VALUE_HI:
				rd_mux = {1'b0, phase_offset_value_ovf_ff, phase_offset_value_ie_ff, phase_offset_value_rdy_ff,
					phase_offset_value_busy_ff, phase_offset_value_val_ff[10:8]};
			csf_pkg::IDX_PHASE_OFFSET_VALUE_LO: rd_mux = phase_offset_value_val_ff[7:0];
			csf_pkg::IDX_PHADJ:
				rd_mux = {csf_pkg::PHADJ_RST[7:4], adj_ie_ff, adj_done_ff,
					adj_busy_ff, adj_armed_ff};
			csf_pkg::IDX_GLOB_SUM: rd_mux = {6'h00, PA_IRQ, PHASE_OFFSET_VALUE_IRQ};
			csf_pkg::IDX_OUT_SUM:  rd_mux = 8'(OUT_IRQ);
			csf_pkg::IDX_SLOW_CTRL: rd_mux = 8'(slow_rep_en_ff);
			default: begin
				for (int k = 0; k < NOUT; k++)
					if (ap_addr_ff == csf_pkg::IDX_OUT1 + 8'(k))
						rd_mux = oc_ff[k];
			end
		endcase
	end

	// Read data registered; costs one wait state per read
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HRESP <= 1'b0;
			if (HSEL && HREADY && HTRANS[1] && !HWRITE)
				HREADYOUT <= 1'b0;
			else
				HREADYOUT <= 1'b1;
			if (ap_read_ff)
				HRDATA <= {24'h000000, rd_mux};
		end
	end

	// Checks; one clock domain, quiet while reset is high
	// ready flag sets
	a_ready_set: assert property (@(posedge CORE_CLK)
		disable iff (RST) PHASE_OFFSET_VALUE_DONE |=> phase_offset_value_rdy_ff)
		else $error("ready flag not set");
	a_ovf_track: assert property (@(posedge CORE_CLK)
		disable iff (RST) PHASE_OFFSET_VALUE_DONE |=> phase_offset_value_ovf_ff == $past(PHASE_OFFSET_VALUE_OVF))
		else $error("overflow flag wrong");
	a_phase_offset_value_busy: assert property (@(posedge CORE_CLK)
		disable iff (RST) 1'b1 |=> phase_offset_value_busy_ff == $past(PHASE_OFFSET_VALUE_BUSY))
		else $error("measure busy wrong");
	a_phase_offset_value_irq: assert property (@(posedge CORE_CLK)
		disable iff (RST) PHASE_OFFSET_VALUE_DONE && phase_offset_value_ie_ff && !wr_hit
		|-> ##2 PHASE_OFFSET_VALUE_IRQ) else $error("measure request missing");
	a_phase_offset_value_quiet: assert property (@(posedge CORE_CLK)
		disable iff (RST) !phase_offset_value_ie_ff |=> !PHASE_OFFSET_VALUE_IRQ)
		else $error("measure request unmasked");
	a_phase_offset_value_value: assert property (@(posedge CORE_CLK)
		disable iff (RST) PHASE_OFFSET_VALUE_DONE |=> phase_offset_value_val_ff == $past(PHASE_OFFSET_VALUE_VALUE))
		else $error("measure value wrong");
	a_phase_offset_value_clear: assert property (@(posedge CORE_CLK)
		disable iff (RST) wr_hit && ap_addr_ff == csf_pkg::IDX_PHASE_OFFSET_VALUE_HI
		&& wbyte[csf_pkg::MH_RDY] && !PHASE_OFFSET_VALUE_DONE |=> !phase_offset_value_rdy_ff)
		else $error("ready flag not cleared");
	a_adj_done: assert property (@(posedge CORE_CLK)
		disable iff (RST) ADJ_DONE |=> adj_done_ff)
		else $error("done flag not set");
	a_adj_clear: assert property (@(posedge CORE_CLK)
		disable iff (RST) wr_hit && ap_addr_ff == csf_pkg::IDX_PHADJ
		&& wbyte[csf_pkg::PA_DONE] && !ADJ_DONE |=> !adj_done_ff)
		else $error("done flag not cleared");
	a_adj_irq: assert property (@(posedge CORE_CLK)
		disable iff (RST) !adj_ie_ff |=> !PA_IRQ)
		else $error("adjust request unmasked");
	a_pa_summary: assert property (@(posedge CORE_CLK)
		disable iff (RST) adj_ie_ff && adj_done_ff |=> PA_IRQ)
		else $error("adjust request missing");
	a_adj_busy: assert property (@(posedge CORE_CLK)
		disable iff (RST) 1'b1 |=> adj_busy_ff == $past(ADJ_BUSY))
		else $error("adjust busy wrong");
	a_armed_live: assert property (@(posedge CORE_CLK)
		disable iff (RST) $fell(ADJ_ARMED) |=> !adj_armed_ff)
		else $error("armed bit stuck");
	a_slow_edge: assert property (@(posedge CORE_CLK)
		disable iff (RST) edge_arm_ff && $rose(SLOW_CLK[0])
		|=> oc_ff[0][csf_pkg::OC_SLL])
		else $error("slow edge not latched");
	a_last_output: assert property (@(posedge CORE_CLK)
		disable iff (RST) edge_arm_ff && $rose(SLOW_CLK[NOUT-1])
		|=> oc_ff[NOUT-1][csf_pkg::OC_SLL])
		else $error("last output edge not latched");
	a_slow_level: assert property (@(posedge CORE_CLK)
		disable iff (RST) 1'b1 |=> oc_ff[0][csf_pkg::OC_SLV]
		== ($past(slow_rep_en_ff[0]) && !$past(SLOW_CLK[0])))
		else $error("slow level wrong");
	a_resume_set: assert property (@(posedge CORE_CLK)
		disable iff (RST) edge_arm_ff && PATH_READY[0]
		&& $fell(CLK_STOPPED[0]) |=> oc_ff[0][csf_pkg::OC_RSL])
		else $error("resume not latched");
	a_halt_set: assert property (@(posedge CORE_CLK)
		disable iff (RST) edge_arm_ff && PATH_READY[0]
		&& $rose(CLK_STOPPED[0]) |=> oc_ff[0][csf_pkg::OC_HLL])
		else $error("halt not latched");
	a_halt_lvl: assert property (@(posedge CORE_CLK)
		disable iff (RST) PATH_READY[0] && CLK_STOPPED[0]
		|=> oc_ff[0][csf_pkg::OC_HLV]) else $error("halt level wrong");
	a_path_quiet: assert property (@(posedge CORE_CLK)
		disable iff (RST) !PATH_READY[0] |=> !oc_ff[0][csf_pkg::OC_RSL]
		&& !oc_ff[0][csf_pkg::OC_HLL] && !oc_ff[0][csf_pkg::OC_HLV])
		else $error("clock path bits set");
	a_out_slow: assert property (@(posedge CORE_CLK)
		disable iff (RST) oc_ff[0][csf_pkg::OC_SLIE]
		&& oc_ff[0][csf_pkg::OC_SLL] |=> OUT_IRQ[0])
		else $error("slow edge request missing");
	a_out_resume: assert property (@(posedge CORE_CLK)
		disable iff (RST) oc_ff[0][csf_pkg::OC_RSIE]
		&& oc_ff[0][csf_pkg::OC_RSL] |=> OUT_IRQ[0])
		else $error("resume request missing");
	a_out_halt: assert property (@(posedge CORE_CLK)
		disable iff (RST) oc_ff[0][csf_pkg::OC_HLIE]
		&& oc_ff[0][csf_pkg::OC_HLL] |=> OUT_IRQ[0])
		else $error("halt request missing");
	a_out_quiet: assert property (@(posedge CORE_CLK)
		disable iff (RST) !oc_ff[0][csf_pkg::OC_SLIE]
		&& !oc_ff[0][csf_pkg::OC_RSIE] && !oc_ff[0][csf_pkg::OC_HLIE]
		|=> !OUT_IRQ[0]) else $error("output request unmasked");

	// Main scenarios
	c_phase_offset_value: cover property (@(posedge CORE_CLK) PHASE_OFFSET_VALUE_DONE ##2 PHASE_OFFSET_VALUE_IRQ);
	c_adj: cover property (@(posedge CORE_CLK) ADJ_DONE ##2 PA_IRQ);
	c_out: cover property (@(posedge CORE_CLK) OUT_IRQ[0]);
	c_resume: cover property (@(posedge CORE_CLK)
		OUT_IRQ[0] && oc_ff[0][csf_pkg::OC_RSL]);
	c_clear: cover property (@(posedge CORE_CLK)
		adj_done_ff ##1 !adj_done_ff);
endmodule : csf_top

/* tb/csf_tb.sv */
`timescale 1ns/1ps
module tb;
	logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic        m_done, m_ovf, m_busy, a_done, a_busy, a_armed;
	logic [10:0] m_val;
	logic [2:0]  slow, stopped, path, out_irq, m, hsize;
	logic        pa_irq, phase_offset_value_irq, ovf, ie, bz;
	logic [7:0]  rd, idx;
	int          n_fail, cmp_count;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	csf_top DUT (.CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .PHASE_OFFSET_VALUE_DONE(m_done),
		.PHASE_OFFSET_VALUE_OVF(m_ovf), .PHASE_OFFSET_VALUE_VALUE(m_val), .PHASE_OFFSET_VALUE_BUSY(m_busy),
		.ADJ_DONE(a_done), .ADJ_BUSY(a_busy), .ADJ_ARMED(a_armed),
		.SLOW_CLK(slow), .CLK_STOPPED(stopped), .PATH_READY(path),
		.PA_IRQ(pa_irq), .PHASE_OFFSET_VALUE_IRQ(phase_offset_value_irq), .OUT_IRQ(out_irq));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [7:0] mh(logic o, e, r, b, logic [10:0] v);
		return {1'b0, o, e, r, b, v[10:8]};
	endfunction : mh

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= csf_pkg::HTRANS_NONSEQ;
		haddr <= {22'h0, a, 2'h0};
		hwrite <= wr;
		hsize <= csf_pkg::HSIZE_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask : bus

	task automatic chk(input string nm, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, e, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, e, rd);
	endtask : rdchk

	// Levels and flags land one cycle late; leave margin
	task automatic w;
		repeat (4) @(posedge clk);
	endtask : w

	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		give_verdict;
	end

	initial begin
		{hsel, hwrite, m_done, m_ovf, m_busy, a_done, a_busy, a_armed} = '0;
		htrans = 2'h0;
		hsize = 3'h0;
		haddr = '0;
		hwdata = '0;
		m_val = '0;
		slow = '0;
		stopped = 3'h7;
		path = '0;
		rst = 1'b1;
		n_fail = 0;
		cmp_count = 0;
		void'($urandom(71));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdchk(csf_pkg::IDX_PHADJ, csf_pkg::PHADJ_RST, "pa_reset");
		for (int i = 0; i < 3; i++)
			rdchk(8'(csf_pkg::IDX_OUT1 + i), 8'h00, "oc_unclocked");
		// Both range ends first, then random results
		for (int k = 0; k < 4; k++) begin
			ovf = 1'($urandom);
			ie = 1'($urandom);
			bz = 1'($urandom);
			m_val <= (k == 0) ? 11'h3FF : (k == 1) ? 11'h400 : 11'($urandom);
			m_ovf <= ovf;
			m_busy <= bz;
			bus(1'b1, csf_pkg::IDX_PHASE_OFFSET_VALUE_HI, {2'h0, ie, 5'h00});
			m_done <= 1'b1;
			@(posedge clk);
			m_done <= 1'b0;
			w;
			rdchk(csf_pkg::IDX_PHASE_OFFSET_VALUE_HI, mh(ovf, ie, 1'b1, bz, m_val),
				"phase_offset_value_hi");
			rdchk(csf_pkg::IDX_PHASE_OFFSET_VALUE_LO, m_val[7:0], "phase_offset_value_lo");
			chk("phase_offset_value_irq", {7'h0, ie}, {7'h0, phase_offset_value_irq});
			rdchk(csf_pkg::IDX_GLOB_SUM, {7'h0, ie}, "glob_phase_offset_value");
			bus(1'b1, csf_pkg::IDX_PHASE_OFFSET_VALUE_HI, {2'h1, ie, 5'h10});
			w;
			rdchk(csf_pkg::IDX_PHASE_OFFSET_VALUE_HI, mh(1'b0, ie, 1'b0, bz, m_val), "phase_offset_value_clr");
			chk("phase_offset_value_irq", 8'h00, {7'h0, phase_offset_value_irq});
		end
		a_armed <= 1'b1;
		w;
		rdchk(csf_pkg::IDX_PHADJ, 8'h85, "pa_armed");
		a_armed <= 1'b0;
		a_busy <= 1'b1;
		bus(1'b1, csf_pkg::IDX_PHADJ, 8'h04);
		w;
		rdchk(csf_pkg::IDX_PHADJ, 8'h82, "pa_busy");
		a_busy <= 1'b0;
		a_done <= 1'b1;
		@(posedge clk);
		a_done <= 1'b0;
		w;
		rdchk(csf_pkg::IDX_PHADJ, 8'h84, "pa_done");
		chk("pa_irq", 8'h00, {7'h0, pa_irq});
		bus(1'b1, csf_pkg::IDX_PHADJ, 8'h08);
		w;
		chk("pa_irq", 8'h01, {7'h0, pa_irq});
		rdchk(csf_pkg::IDX_GLOB_SUM, 8'h02, "glob_sum");
		bus(1'b1, csf_pkg::IDX_PHADJ, 8'h0C);
		w;
		rdchk(csf_pkg::IDX_PHADJ, 8'h88, "pa_clr");
		chk("pa_irq", 8'h00, {7'h0, pa_irq});
		stopped <= 3'h0;
		w;
		path <= 3'h7;
		w;
		for (int i = 0; i < 3; i++) begin
			idx = 8'(csf_pkg::IDX_OUT1 + i);
			m = 3'(1 << i);
			rdchk(idx, 8'h00, "oc_idle");
			bus(1'b1, csf_pkg::IDX_SLOW_CTRL, {5'h0, m});
			w;
			rdchk(idx, 8'h20, "oc_level");
			slow <= m;
			w;
			rdchk(idx, 8'h40, "oc_edge");
			stopped <= m;
			w;
			rdchk(idx, 8'h43, "oc_stop");
			bus(1'b1, idx, 8'h94);
			w;
			chk("out_irq", {5'h0, m}, {5'h0, out_irq});
			rdchk(csf_pkg::IDX_OUT_SUM, {5'h0, m}, "out_sum");
			stopped <= 3'h0;
			w;
			rdchk(idx, 8'hDE, "oc_start");
			bus(1'b1, idx, 8'h4A);
			w;
			rdchk(idx, 8'h00, "oc_clr");
			chk("out_irq", 8'h00, {5'h0, out_irq});
			slow <= 3'h0;
			bus(1'b1, csf_pkg::IDX_SLOW_CTRL, 8'h00);
		end
		bus(1'b1, 8'h70, 8'hFF);
		rdchk(8'h70, 8'h00, "unmapped");
		chk("hresp", 8'h00, {7'h0, hresp});
		give_verdict;
	end
endmodule : tb
